// ---- verilog/interval_timer.sv ----
// Purpose: 16-bit clear-on-match interval timer with AXI4-Lite registers
// Assumes: Software keeps the programming restrictions below
// Notes: Counter runs on aclk with a count enable, not a gated clock
// Operation
// - Hidden 16-bit up-counter counts selected clock
// - Compare register 16 bits, reset zero
// - Control register 8 bits, reset zero
// - Rewriting same control, compare or mask value is harmless
// - Run bit low stops and clears counter
// - Run bit high starts counting
// - Three-bit select picks one of eight sources
// - Counter wraps from all-ones to zero first
// - Match clears counter next tick, raises interrupt
// - Compare zero interrupts on every tick after the first
// - Counting starts within bounded delay after enable
// - Only clear-on-match mode exists
`timescale 1ns/100ps
`default_nettype none
module interval_timer
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [interval_timer_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [interval_timer_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Count sources from other units
    input wire logic watch_tick_event,
    input wire logic internal_osc_clk,
    input wire logic sub_clock,
    // Events
    output logic compare_match_irq,
    output logic irq
);
    logic [7:0] interval_timer_control_ff;
    logic [15:0] interval_compare_value_ff;
    logic [15:0] count_ff;
    logic started_ff;
    logic irq_status_ff;
    logic irq_mask_ff;
    logic [interval_timer_pkg::ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_have_ff;
    logic w_have_ff;
    logic count_tick;
    logic match;
    logic do_write;
    logic do_read;
    logic wr_ok;
    logic w1c_status;
    logic [31:0] nxt_rdata;
    logic [1:0] nxt_rresp;
    logic nxt_aw_have;
    logic nxt_w_have;
    logic nxt_bvalid;
    logic nxt_rvalid;
    interval_timer_pkg::timer_ctrl_s ctrl;

    assign ctrl.run = interval_timer_control_ff[interval_timer_pkg::RUN_BIT];
    assign ctrl.sel = interval_timer_pkg::count_sel_e'(
        interval_timer_control_ff[interval_timer_pkg::SEL_LO +: interval_timer_pkg::SEL_W]);

    count_tick_gen u_tick
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .ctrl(ctrl),
        .watch_tick_event(watch_tick_event),
        .internal_osc_clk(internal_osc_clk),
        .sub_clock(sub_clock),
        .count_tick(count_tick)
    );

    // Write channels, taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            else if (do_write)
                aw_have_ff <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            else if (do_write)
                w_have_ff <= 1'b0;
        end
    end

    assign do_write = aw_have_ff && w_have_ff && !s_axi_bvalid;

    // Next handshake state, so every ready can come straight from a flop
    always_comb
    begin
        nxt_aw_have = aw_have_ff;
        nxt_w_have = w_have_ff;
        nxt_bvalid = s_axi_bvalid;
        nxt_rvalid = s_axi_rvalid;
        if (s_axi_awvalid && s_axi_awready)
            nxt_aw_have = 1'b1;
        else if (do_write)
            nxt_aw_have = 1'b0;
        if (s_axi_wvalid && s_axi_wready)
            nxt_w_have = 1'b1;
        else if (do_write)
            nxt_w_have = 1'b0;
        if (do_write)
            nxt_bvalid = 1'b1;
        else if (s_axi_bready)
            nxt_bvalid = 1'b0;
        if (do_read)
            nxt_rvalid = 1'b1;
        else if (s_axi_rready)
            nxt_rvalid = 1'b0;
    end

    // Same timing as a decode of the held state, without a combinational output
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_arready <= 1'b1;
        end
        else
        begin
            s_axi_awready <= !nxt_aw_have && !nxt_bvalid;
            s_axi_wready <= !nxt_w_have && !nxt_bvalid;
            s_axi_arready <= !nxt_rvalid;
        end
    end

    // Compare takes only a whole 16-bit write
    assign wr_ok = (awaddr_ff == interval_timer_pkg::OFS_COMPARE) ? (wstrb_ff[1:0] == 2'h3) :
                   (awaddr_ff == interval_timer_pkg::OFS_CONTROL ||
                    awaddr_ff == interval_timer_pkg::OFS_IRQ_STATUS ||
                    awaddr_ff == interval_timer_pkg::OFS_IRQ_MASK ||
                    awaddr_ff == interval_timer_pkg::OFS_TIMER_STATE);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= interval_timer_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? interval_timer_pkg::RESP_OKAY : interval_timer_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Byte-wide control; bits 3-6 kept zero whatever is written
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            interval_timer_control_ff <= interval_timer_pkg::CONTROL_RESET;
        else if (do_write && awaddr_ff == interval_timer_pkg::OFS_CONTROL && wstrb_ff[0])
            interval_timer_control_ff <= wdata_ff[7:0] & interval_timer_pkg::CONTROL_WMASK;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            interval_compare_value_ff <= interval_timer_pkg::COMPARE_RESET;
        else if (do_write && awaddr_ff == interval_timer_pkg::OFS_COMPARE && wstrb_ff[1:0] == 2'h3)
            interval_compare_value_ff <= wdata_ff[15:0];
    end

    // Match against compare, only clear-on-match mode
    assign match = started_ff && (count_ff == interval_compare_value_ff);

    // Stopped counter sits at all-ones so first tick wraps to zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !ctrl.run)
        begin
            count_ff <= 16'hFFFF;
            started_ff <= 1'b0;
        end
        else if (count_tick)
        begin
            started_ff <= 1'b1;
            if (!started_ff || match)
                count_ff <= 16'h0000;
            else
                count_ff <= count_ff + 16'h0001;
        end
    end

    // Pulse on the tick that clears after a match
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !ctrl.run)
            compare_match_irq <= 1'b0;
        else
            compare_match_irq <= count_tick && match;
    end

    assign w1c_status = do_write && awaddr_ff == interval_timer_pkg::OFS_IRQ_STATUS &&
                        wstrb_ff[0] && wdata_ff[0];

    // Set wins over write-one-to-clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_status_ff <= 1'b0;
        else if (compare_match_irq)
            irq_status_ff <= 1'b1;
        else if (w1c_status)
            irq_status_ff <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_mask_ff <= 1'b0;
        else if (do_write && awaddr_ff == interval_timer_pkg::OFS_IRQ_MASK && wstrb_ff[0])
            irq_mask_ff <= wdata_ff[0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq <= 1'b0;
        else
            irq <= (irq_status_ff || compare_match_irq) && irq_mask_ff;
    end

    // Read path; counter value is never exposed
    assign do_read = s_axi_arvalid && s_axi_arready;

    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = interval_timer_pkg::RESP_OKAY;
        case (s_axi_araddr)
            interval_timer_pkg::OFS_CONTROL: nxt_rdata[7:0] = interval_timer_control_ff;
            interval_timer_pkg::OFS_COMPARE: nxt_rdata[15:0] = interval_compare_value_ff;
            interval_timer_pkg::OFS_IRQ_STATUS: nxt_rdata[0] = irq_status_ff;
            interval_timer_pkg::OFS_IRQ_MASK: nxt_rdata[0] = irq_mask_ff;
            interval_timer_pkg::OFS_TIMER_STATE: nxt_rdata[0] = started_ff;
            default: nxt_rresp = interval_timer_pkg::RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= interval_timer_pkg::RESP_OKAY;
        end
        else if (do_read)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= nxt_rdata;
            s_axi_rresp <= nxt_rresp;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Checks
    sequence run_rise_s;
        $rose(ctrl.run);
    endsequence

    stop_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(ctrl.run) |=> count_ff == 16'hFFFF && !compare_match_irq)
        else $error("counter not cleared when stopped");
    first_tick_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl.run && count_tick && !started_ff |=> count_ff == 16'h0000)
        else $error("first tick did not wrap to zero");
    match_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl.run && count_tick && match ##1 ctrl.run |-> count_ff == 16'h0000 && compare_match_irq)
        else $error("match did not clear and interrupt");
    count_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl.run && count_tick && started_ff && !match ##1 ctrl.run
        |-> count_ff == $past(count_ff) + 16'h0001)
        else $error("counter did not step by one");
    zero_every_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl.run && started_ff && interval_compare_value_ff == 16'h0000 && count_tick ##1 ctrl.run
        |-> compare_match_irq)
        else $error("compare zero missed a tick");
    // Relies on the clear after a match, so a stuck counter shows here when SEL_MAIN ticks every cycle
    irq_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
        compare_match_irq && interval_compare_value_ff != 16'h0000 |=> !compare_match_irq)
        else $error("match pulse too long");
    main_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
        run_rise_s ##0 ctrl.sel == interval_timer_pkg::SEL_MAIN ##1 ctrl.run |-> started_ff)
        else $error("main clock start too late");
    ctrl_reserved_a: assert property (@(posedge aclk) disable iff (!aresetn)
        interval_timer_control_ff[6:3] == 4'h0)
        else $error("reserved control bits set");
    sel_main4_a: assert property (@(posedge aclk) disable iff (!aresetn)
        run_rise_s ##0 ctrl.sel == interval_timer_pkg::SEL_MAIN_4 ##1 ctrl.run [*4]
        |-> started_ff)
        else $error("divide by four not honoured");
    compare_whole_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && awaddr_ff == interval_timer_pkg::OFS_COMPARE && wstrb_ff[1:0] != 2'h3
        |=> $stable(interval_compare_value_ff))
        else $error("partial compare write was stored");
endmodule
`default_nettype wire

// ---- verilog/interval_timer_pkg.sv ----
// Purpose: Shared constants and types for the 16-bit interval timer
// Assumes: AXI4-Lite slave, 32-bit data, one clock at 25 MHz
// Notes: Offsets are byte addresses
package interval_timer_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_COMPARE = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_TIMER_STATE = 8'h10;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] COMPARE_RESET = 16'h0000;
    localparam int RUN_BIT = 7;
    localparam int SEL_LO = 0;
    localparam int SEL_W = 3;
    localparam logic [7:0] CONTROL_WMASK = 8'h87;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int DIV2 = 2;
    localparam int DIV4 = 4;
    localparam int DIV64 = 64;
    localparam int DIV512 = 512;
    localparam int OSC_DIV = 8;
    localparam int PRESCALE_W = 9;
    typedef enum logic [2:0] {
        SEL_MAIN, SEL_MAIN_2, SEL_MAIN_4, SEL_MAIN_64,
        SEL_MAIN_512, SEL_WATCH_TICK, SEL_OSC_8, SEL_SUBCLOCK
    } count_sel_e;
    typedef struct packed {
        logic run;
        count_sel_e sel;
    } timer_ctrl_s;
endpackage

// ---- verilog/count_tick_gen.sv ----
// Purpose: Produces one-cycle count enables from the selected source
// Assumes: External sources already pass two flip-flops here
// Notes: Prescaler held clear while stopped
`timescale 1ns/100ps
`default_nettype none
module count_tick_gen
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire interval_timer_pkg::timer_ctrl_s ctrl,
    // External sources
    input wire logic watch_tick_event,
    input wire logic internal_osc_clk,
    input wire logic sub_clock,
    // Count enable
    output logic count_tick
);
    logic [interval_timer_pkg::PRESCALE_W-1:0] prescale_ff;
    logic [2:0] sync_ff [2];
    logic [2:0] last_ff;
    logic [2:0] osc_div_ff;
    logic [2:0] rise;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !ctrl.run)
            prescale_ff <= '0;
        else
            prescale_ff <= prescale_ff + 1'b1;
    end

    // Level sync; stage one feeds only stage two
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_ff[0] <= 3'h0;
            sync_ff[1] <= 3'h0;
            last_ff <= 3'h0;
        end
        else
        begin
            sync_ff[0] <= {sub_clock, internal_osc_clk, watch_tick_event};
            sync_ff[1] <= sync_ff[0];
            last_ff <= sync_ff[1];
        end
    end

    assign rise = sync_ff[1] & ~last_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !ctrl.run)
            osc_div_ff <= 3'h0;
        else if (rise[1])
            osc_div_ff <= osc_div_ff + 1'b1;
    end

    function automatic logic div_hit(input logic [8:0] cnt, input int div);
        div_hit = (cnt & 9'(div - 1)) == 9'(div - 1);
    endfunction

    // Source choice per select code
    always_comb
    begin
        case (ctrl.sel)
            interval_timer_pkg::SEL_MAIN: count_tick = 1'b1;
            interval_timer_pkg::SEL_MAIN_2: count_tick = div_hit(prescale_ff, interval_timer_pkg::DIV2);
            interval_timer_pkg::SEL_MAIN_4: count_tick = div_hit(prescale_ff, interval_timer_pkg::DIV4);
            interval_timer_pkg::SEL_MAIN_64: count_tick = div_hit(prescale_ff, interval_timer_pkg::DIV64);
            interval_timer_pkg::SEL_MAIN_512: count_tick = div_hit(prescale_ff, interval_timer_pkg::DIV512);
            interval_timer_pkg::SEL_WATCH_TICK: count_tick = rise[0];
            interval_timer_pkg::SEL_OSC_8: count_tick = rise[1] && (osc_div_ff == 3'(interval_timer_pkg::OSC_DIV - 1));
            interval_timer_pkg::SEL_SUBCLOCK: count_tick = rise[2];
            default: count_tick = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ---- tb/interval_timer_tb.sv ----
// Purpose: Self-checking bench for the 16-bit interval timer
// Assumes: Bench acts as AXI4-Lite master; external sources are made from aclk
// Notes: Periods are measured between match pulses, so any jitter shows
`timescale 1ns/100ps
`default_nettype none
module interval_timer_tb;
    logic aclk;
    logic aresetn;
    logic [7:0] awaddr;
    logic [7:0] araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic watch_tick_event, internal_osc_clk, sub_clock, compare_match_irq, irq;
    int error_cnt, n_compared, cyc, i, n;
    logic [15:0] lfsr;
    logic [31:0] m_reg [5];
    int per_t [8] = '{1, 2, 4, 64, 512, 30, 48, 20};
    int lat_t [8] = '{2, 3, 6, 128, 1024, 60, 96, 40};
    interval_timer u_interval_timer (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .watch_tick_event(watch_tick_event), .internal_osc_clk(internal_osc_clk),
        .sub_clock(sub_clock), .compare_match_irq(compare_match_irq), .irq(irq));
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic wrap_up();
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        chk(32'h0, 32'h1);
        wrap_up();
    endtask
    // Edge first, so a release and a new request never share a time step
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        int k;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 100; k++)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
                break;
        end
        if (k == 100)
            hang();
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 100; k++)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
                break;
        end
        if (k == 100)
            hang();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] e);
        logic [1:0] r;
        axi_write(a, d, s, r);
        chk(32'(r), 32'(e));
        if (r === interval_timer_pkg::RESP_OKAY && s[0] && a <= interval_timer_pkg::OFS_IRQ_MASK)
        begin
            if (a == interval_timer_pkg::OFS_CONTROL)
                m_reg[0] = d & 32'(interval_timer_pkg::CONTROL_WMASK);
            else if (a == interval_timer_pkg::OFS_COMPARE)
                m_reg[1] = d & 32'h0000FFFF;
            else if (a == interval_timer_pkg::OFS_IRQ_STATUS)
                m_reg[2] = m_reg[2] & ~(d & 32'h00000001);
            else
                m_reg[3] = d & 32'h00000001;
        end
    endtask
    task automatic rd_chk(input logic [7:0] a);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        chk(d, m_reg[a[4:2]]);
        chk(32'(r), 32'(interval_timer_pkg::RESP_OKAY));
    endtask
    task automatic wait_pulse(input int lim, output int t);
        for (t = 1; t <= lim; t++)
        begin
            @(posedge aclk);
            if (compare_match_irq === 1'b1)
                break;
        end
        if (t > lim)
            hang();
    endtask
    task automatic run_case(input int sel, input int cmp);
        int t, p, l, k, cnt;
        p = per_t[sel];
        l = lat_t[sel];
        wr(interval_timer_pkg::OFS_CONTROL, 32'(sel), 4'hF, 2'h0);
        wr(interval_timer_pkg::OFS_COMPARE, 32'(cmp), 4'hF, 2'h0);
        wr(interval_timer_pkg::OFS_CONTROL, 32'h80 | 32'(sel), 4'hF, 2'h0);
        wait_pulse(l + (cmp + 1) * p + 8, t);
        wait_pulse((cmp + 2) * p + 8, t);
        chk(32'(t), 32'((cmp + 1) * p));
        m_reg[4] = 32'h1;
        rd_chk(interval_timer_pkg::OFS_TIMER_STATE);
        wr(interval_timer_pkg::OFS_CONTROL, 32'h80 | 32'(sel), 4'hF, 2'h0);
        wr(interval_timer_pkg::OFS_COMPARE, 32'(cmp), 4'hF, 2'h0);
        wait_pulse((cmp + 2) * p + 8, t);
        wait_pulse((cmp + 2) * p + 8, t);
        chk(32'(t), 32'((cmp + 1) * p));
        wr(interval_timer_pkg::OFS_CONTROL, 32'(sel), 4'hF, 2'h0);
        m_reg[2] = 32'h1;
        m_reg[4] = 32'h0;
        cnt = 0;
        repeat (2) @(posedge aclk);
        for (k = 0; k < 600; k++)
        begin
            @(posedge aclk);
            if (compare_match_irq !== 1'b0)
                cnt++;
        end
        chk(32'(cnt), 32'h0);
        rd_chk(interval_timer_pkg::OFS_TIMER_STATE);
    endtask
    // Outside sources, deterministic so the measured periods are exact
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        sub_clock <= (cyc % 20) < 10;
        internal_osc_clk <= (cyc % 6) < 3;
        watch_tick_event <= (cyc % 30) < 3;
    end
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        aresetn = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        error_cnt = 0;
        n_compared = 0;
        lfsr = 16'h5211;
        for (i = 0; i < 5; i++)
            m_reg[i] = 32'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 5; i++)
            rd_chk(8'(i * 4));
        axi_read(8'h20, d, r);
        chk(d, 32'h0);
        chk(32'(r), 32'(interval_timer_pkg::RESP_SLVERR));
        wr(8'h24, 32'h1, 4'hF, interval_timer_pkg::RESP_SLVERR);
        wr(interval_timer_pkg::OFS_COMPARE, 32'h1234, 4'h1, interval_timer_pkg::RESP_SLVERR);
        rd_chk(interval_timer_pkg::OFS_COMPARE);
        wr(interval_timer_pkg::OFS_CONTROL, 32'h2, 4'h1, 2'h0);
        rd_chk(interval_timer_pkg::OFS_CONTROL);
        for (i = 0; i < 8; i++)
        begin
            lfsr = lfsr_next(lfsr);
            n = (i == 3 || i == 4) ? 1 + int'(lfsr[0]) : 1 + int'(lfsr[3:0]);
            run_case(i, n);
        end
        run_case(1, 0);
        rd_chk(interval_timer_pkg::OFS_IRQ_STATUS);
        chk(32'(irq), 32'h0);
        wr(interval_timer_pkg::OFS_IRQ_MASK, 32'h1, 4'hF, 2'h0);
        repeat (3) @(posedge aclk);
        chk(32'(irq), 32'h1);
        wr(interval_timer_pkg::OFS_IRQ_STATUS, 32'h1, 4'hF, 2'h0);
        repeat (3) @(posedge aclk);
        chk(32'(irq), 32'h0);
        rd_chk(interval_timer_pkg::OFS_IRQ_STATUS);
        rd_chk(interval_timer_pkg::OFS_IRQ_MASK);
        wrap_up();
    end
endmodule
`default_nettype wire
